/* File: dv/lan_source_model.sv */
`timescale 1ns/1ps
// live lan sources: {wp, ready, interesting, pattern, link, interrupt}
module lan_source_model (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [5:0] i_want,
  output reg  [5:0] o_src
);
  // pending stays up until the driver's acknowledgement drops i_want
  always @(posedge i_clk) begin
    o_src <= i_rst_n ? i_want : 6'h00;
  end
endmodule // lan_source_model

/* File: dv/lan_status_force_sva.sv */
`timescale 1ns/1ps
module lan_status_force_sva (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [4:0]  i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  input wire        i_lan_interrupt_source,
  input wire        i_power_mgmt_driver_register_link_change,
  input wire        i_power_mgmt_driver_register_pattern_frame,
  input wire        i_power_mgmt_driver_register_interesting_frame,
  input wire        i_battery_detect_ready,
  input wire        i_battery_detect_write_protect
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire rd0 = o_wb_ack && !i_wb_we && i_wb_adr == 5'h00;
  ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack)
    else $error("ack late");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("data without ack");
  rsvd_zero_a: assert property (rd0 |-> (o_wb_dat & 32'hffff_7fe9) == 0)
    else $error("reserved bit set");
  lan_interrupt_source_live_a: assert property (rd0
    |-> o_wb_dat[15] == $past(i_lan_interrupt_source))
    else $error("interrupt bit wrong");
  wake_src_a: assert property (rd0 && o_wb_dat[4]
    |-> $past(i_power_mgmt_driver_register_link_change | i_power_mgmt_driver_register_pattern_frame
    | i_power_mgmt_driver_register_interesting_frame))
    else $error("wake bit without source");
  batt_bits_a: assert property (rd0
    |-> o_wb_dat[2:1] == {$past(i_battery_detect_ready),
    $past(i_battery_detect_write_protect)})
    else $error("battery bits wrong");
  force_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 5'h04
    |-> o_wb_dat == 32'h0)
    else $error("force reads nonzero");
endmodule // lan_status_force_sva
bind lan_status_force lan_status_force_sva u_sva (.*);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg         i_clk, i_rst_n, cyc, stb, we;
  reg  [4:0]  adr;
  reg  [5:0]  want;
  reg  [31:0] wd, q;
  wire [5:0]  src;
  wire [31:0] o_wb_dat;
  wire        o_wb_ack, o_inta_n, o_cstschg, o_irq;
  integer     failures, n_checks, n;
  lan_source_model u_src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_want(want),
    .o_src(src));
  lan_status_force dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wd), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_lan_interrupt_source(src[0]), .i_power_mgmt_driver_register_link_change(src[1]),
    .i_power_mgmt_driver_register_pattern_frame(src[2]), .i_power_mgmt_driver_register_interesting_frame(src[3]),
    .i_battery_detect_ready(src[4]), .i_battery_detect_write_protect(src[5]),
    .o_inta_n(o_inta_n), .o_cstschg(o_cstschg), .o_irq(o_irq));
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  task close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // waits on ack itself; only the bounded count ends a hung access
  task wb(input [4:0] a, input w, input [31:0] d);
    @(posedge i_clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    n = 0;
    do begin @(posedge i_clk); n = n + 1; end
    while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    if (n >= 20) failures = failures + 1;
    {cyc, stb} <= 2'b00;
  endtask
  task rd(input [4:0] a, input [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // pins settle one edge after the write edge
  task pins(input [2:0] e);
    repeat (3) @(posedge i_clk);
    chk("pins", {29'h0, e}, {29'h0, o_inta_n, o_cstschg, o_irq});
  endtask
  task wk(input [31:0] c, input [5:0] w, input e);
    wb(5'h10, 1'b1, c);
    want <= w;
    repeat (2) @(posedge i_clk);
    rd(5'h00, {27'h0, e, 4'h0}, "wake");
  endtask
  task t_reset;
    rd(5'h00, 32'h0, "present");
    rd(5'h04, 32'h0, "force");
    rd(5'h1c, 32'h0, "unmapped");
    pins(3'b100);
    $display("t_reset done");
  endtask
  task t_present;
    want <= 6'h31;
    repeat (2) @(posedge i_clk);
    rd(5'h00, 32'h8006, "live");
    want <= 6'h00;
    repeat (2) @(posedge i_clk);
    rd(5'h00, 32'h0, "acked");
    wk(32'h1, 6'h02, 1'b1);
    wk(32'h0, 6'h02, 1'b0);
    wk(32'h0, 6'h04, 1'b1);
    wk(32'h2, 6'h04, 1'b0);
    wk(32'h4, 6'h08, 1'b1);
    wk(32'h0, 6'h08, 1'b0);
    $display("t_present done");
  endtask
  task t_force;
    want <= 6'h00;
    rd(5'h14, 32'h4, "wake rise");
    wb(5'h14, 1'b1, 32'h7);
    wb(5'h08, 1'b1, 32'h8010);
    wb(5'h0c, 1'b1, 32'hc010);
    wb(5'h10, 1'b1, 32'h8);
    wb(5'h18, 1'b1, 32'h3);
    wb(5'h04, 1'b1, 32'h0);
    rd(5'h08, 32'h0, "event");
    wb(5'h04, 1'b1, 32'hffff_6fef);
    rd(5'h08, 32'h0, "event");
    pins(3'b100);
    wb(5'h04, 1'b1, 32'h8000);
    pins(3'b001);
    rd(5'h08, 32'h8000, "event");
    wb(5'h04, 1'b1, 32'h10);
    pins(3'b011);
    rd(5'h08, 32'h8010, "event");
    rd(5'h14, 32'h3, "irq status");
    wb(5'h14, 1'b1, 32'h3);
    pins(3'b010);
    $display("t_force done");
  endtask
  task t_mask;
    wb(5'h08, 1'b1, 32'h8010);
    wb(5'h0c, 1'b1, 32'h0);
    wb(5'h10, 1'b1, 32'h10);
    wb(5'h04, 1'b1, 32'h8010);
    pins(3'b111);
    wb(5'h10, 1'b1, 32'h30);
    rd(5'h08, 32'h8000, "event");
    pins(3'b101);
    $display("t_mask done");
  endtask
  initial begin
    {i_rst_n, cyc, stb, we, adr, wd, want} = 0;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_present;
    t_force;
    t_mask;
    close_out;
  end
  initial begin
    #100000;
    failures = failures + 1;
    close_out;
  end
endmodule // testbench

/* File: rtl/lan_status_defs.vh */
`ifndef LAN_STATUS_DEFS_VH
`define LAN_STATUS_DEFS_VH

// register byte offsets (word aligned)
`define OFS_PRESENT_STATE  4'h0
`define OFS_FORCE_EVENT    4'h4
`define OFS_FUNC_EVENT     4'h8
`define OFS_EVENT_MASK     4'hc
`define OFS_WAKE_CTRL      5'h10
`define OFS_IRQ_STATUS     5'h14
`define OFS_IRQ_MASK       5'h18

// field positions shared by present, force, event and mask registers
`define BIT_LAN_INTERRUPT_SOURCE           15
`define BIT_WKUP           14
`define BIT_GENERAL_WAKE_SOURCE          4
`define BIT_BATT_READY     2
`define BIT_BATT_WP        1

// wake control register fields
`define BIT_LINK_WAKE_EN   0
`define BIT_PATTERN_DIS    1
`define BIT_FILTER_EN      2
`define BIT_HOST_IRQ_EN    3
`define BIT_PME_EN         4
`define BIT_PME_STATUS     5

// interrupt status fields
`define BIT_IRQ_FORCE_INT  0
`define BIT_IRQ_FORCE_WAKE 1
`define BIT_IRQ_WAKE_RISE  2

`define RST_ZERO32         32'h0000_0000
`define RST_WAKE_CTRL      6'h00

`endif

/* File: rtl/lan_status_force.v */
// What this block does
// - present state reserved bits read zero
// - bit 15 mirrors live interrupt source, unmasked
// - interrupt bit follows pending until all acknowledged
// - bit 4 ORs three gated wake bits
// - link change wake gated by enable
// - pattern wake suppressed by disable bit
// - interesting frame wake gated by filter
// - battery ready bit2, write protect bit1
// - force bit 15 sets event interrupt
// - forced interrupt drives intA when unmasked
// - force bit 4 sets status-change event
// - forced wake drives status-change pin when both masks set or pme enabled
// - writing zero to force changes nothing
// - force reserved bits ignored on write
// - intA needs event mask and host mask
// - cstschg needs both masks, or pme enable
// - write one clears general wake and pme
`timescale 1ns/1ps
`include "lan_status_defs.vh"

module lan_status_force (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [4:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire        o_wb_ack,
  // live sources from the lan function
  input  wire        i_lan_interrupt_source,
  input  wire        i_power_mgmt_driver_register_link_change,
  input  wire        i_power_mgmt_driver_register_pattern_frame,
  input  wire        i_power_mgmt_driver_register_interesting_frame,
  input  wire        i_battery_detect_ready,
  input  wire        i_battery_detect_write_protect,
  // card pins and interrupt
  output wire        o_inta_n,
  output wire        o_cstschg,
  output wire        o_irq
);

  reg  [31:0] dat_ff;
  reg         ack_ff;
  reg         inta_n_ff;
  reg         cstschg_ff;
  reg         irq_ff;
  reg  [31:0] nxt_dat;

  // function event and event mask, only the bits we keep
  reg         ev_lan_interrupt_source_ff;
  reg         ev_general_wake_source_ff;
  reg         mask_lan_interrupt_source_ff;
  reg         mask_wkup_ff;
  reg         mask_general_wake_source_ff;
  reg  [5:0]  wake_ctrl_ff;
  reg  [2:0]  irq_status_ff;
  reg  [2:0]  irq_mask_ff;
  reg         general_wake_source_prev_ff;

  wire access    = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire wr        = access & i_wb_we;
  wire lane0     = i_wb_sel[0];
  wire lane1     = i_wb_sel[1];
  wire wr_force  = wr & (i_wb_adr == `OFS_FORCE_EVENT);
  wire wr_event  = wr & (i_wb_adr == `OFS_FUNC_EVENT);
  wire wr_mask   = wr & (i_wb_adr == `OFS_EVENT_MASK);
  wire wr_wctl   = wr & (i_wb_adr == `OFS_WAKE_CTRL);
  wire wr_ists   = wr & (i_wb_adr == `OFS_IRQ_STATUS);
  wire wr_imsk   = wr & (i_wb_adr == `OFS_IRQ_MASK);

  // reserved force bits are simply never looked at
  wire force_int  = wr_force & lane1 &
                    i_wb_dat[`BIT_LAN_INTERRUPT_SOURCE];
  wire force_wake = wr_force & lane0 &
                    i_wb_dat[`BIT_GENERAL_WAKE_SOURCE];

  // gated wake sources
  wire link_w  = i_power_mgmt_driver_register_link_change &
                 wake_ctrl_ff[`BIT_LINK_WAKE_EN];
  wire patt_w  = i_power_mgmt_driver_register_pattern_frame &
                 ~wake_ctrl_ff[`BIT_PATTERN_DIS];
  wire intf_w  = i_power_mgmt_driver_register_interesting_frame &
                 wake_ctrl_ff[`BIT_FILTER_EN];
  wire general_wake_source = link_w | patt_w | intf_w;

  wire clr_general_wake_source = (wr_event & lane0 & i_wb_dat[`BIT_GENERAL_WAKE_SOURCE]) |
                   (wr_wctl & lane0 & i_wb_dat[`BIT_PME_STATUS]);
  wire set_general_wake_source = general_wake_source | force_wake;
  wire wake_rise = general_wake_source & ~general_wake_source_prev_ff;
  wire [2:0] irq_events = {wake_rise, force_wake, force_int};

  // present state composition; everything else stays zero
  wire [31:0] present_state = {16'h0000,
    i_lan_interrupt_source,
    10'h000,
    general_wake_source,
    1'b0, i_battery_detect_ready, i_battery_detect_write_protect,
    1'b0};

  always @* begin
    nxt_dat = `RST_ZERO32;
    if (i_wb_adr == `OFS_PRESENT_STATE) begin
      nxt_dat = present_state;
    end else if (i_wb_adr == `OFS_FORCE_EVENT) begin
      nxt_dat = `RST_ZERO32;
    end else if (i_wb_adr == `OFS_FUNC_EVENT) begin
      nxt_dat[`BIT_LAN_INTERRUPT_SOURCE]  = ev_lan_interrupt_source_ff;
      nxt_dat[`BIT_GENERAL_WAKE_SOURCE] = ev_general_wake_source_ff;
    end else if (i_wb_adr == `OFS_EVENT_MASK) begin
      nxt_dat[`BIT_LAN_INTERRUPT_SOURCE]  = mask_lan_interrupt_source_ff;
      nxt_dat[`BIT_WKUP]  = mask_wkup_ff;
      nxt_dat[`BIT_GENERAL_WAKE_SOURCE] = mask_general_wake_source_ff;
    end else if (i_wb_adr == `OFS_WAKE_CTRL) begin
      nxt_dat[5:0] = wake_ctrl_ff;
    end else if (i_wb_adr == `OFS_IRQ_STATUS) begin
      nxt_dat[2:0] = irq_status_ff;
    end else if (i_wb_adr == `OFS_IRQ_MASK) begin
      nxt_dat[2:0] = irq_mask_ff;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      dat_ff        <= `RST_ZERO32;
      ack_ff        <= 1'b0;
      ev_lan_interrupt_source_ff    <= 1'b0;
      ev_general_wake_source_ff   <= 1'b0;
      mask_lan_interrupt_source_ff  <= 1'b0;
      mask_wkup_ff  <= 1'b0;
      mask_general_wake_source_ff <= 1'b0;
      wake_ctrl_ff  <= `RST_WAKE_CTRL;
      irq_status_ff <= 3'h0;
      irq_mask_ff   <= 3'h0;
      general_wake_source_prev_ff <= 1'b0;
      inta_n_ff     <= 1'b1;
      cstschg_ff    <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      // every address acks, unmapped ones read zero
      ack_ff        <= access;
      dat_ff        <= access ? nxt_dat : `RST_ZERO32;
      general_wake_source_prev_ff <= general_wake_source;

      // event interrupt bit: set beats clear, write-one-to-clear
      if (force_int | i_lan_interrupt_source)
        ev_lan_interrupt_source_ff <= 1'b1;
      else if (wr_event & lane1 & i_wb_dat[`BIT_LAN_INTERRUPT_SOURCE])
        ev_lan_interrupt_source_ff <= 1'b0;

      if (set_general_wake_source)
        ev_general_wake_source_ff <= 1'b1;
      else if (clr_general_wake_source)
        ev_general_wake_source_ff <= 1'b0;

      if (wr_mask & lane1) begin
        mask_lan_interrupt_source_ff <= i_wb_dat[`BIT_LAN_INTERRUPT_SOURCE];
        mask_wkup_ff <= i_wb_dat[`BIT_WKUP];
      end
      if (wr_mask & lane0)
        mask_general_wake_source_ff <= i_wb_dat[`BIT_GENERAL_WAKE_SOURCE];

      if (wr_wctl & lane0)
        wake_ctrl_ff[4:0] <= i_wb_dat[4:0];
      // pme status mirrors general wake; set wins, clears with it
      if (set_general_wake_source)
        wake_ctrl_ff[`BIT_PME_STATUS] <= 1'b1;
      else if (clr_general_wake_source)
        wake_ctrl_ff[`BIT_PME_STATUS] <= 1'b0;

      if (wr_imsk & lane0)
        irq_mask_ff <= i_wb_dat[2:0];
      irq_status_ff <= irq_events |
        (irq_status_ff & ~((wr_ists & lane0) ? i_wb_dat[2:0] : 3'h0));
      irq_ff <= |(irq_status_ff & irq_mask_ff);

      // pins follow event bits, gated by both mask layers; pme enable alone also opens cstschg
      inta_n_ff <= ~(ev_lan_interrupt_source_ff & mask_lan_interrupt_source_ff &
                     wake_ctrl_ff[`BIT_HOST_IRQ_EN]);
      cstschg_ff <= ev_general_wake_source_ff &
        ((mask_wkup_ff & mask_general_wake_source_ff) |
         wake_ctrl_ff[`BIT_PME_EN]);
    end
  end

  assign o_wb_dat  = dat_ff;
  assign o_wb_ack  = ack_ff;
  assign o_inta_n  = inta_n_ff;
  assign o_cstschg = cstschg_ff;
  assign o_irq     = irq_ff;

endmodule // lan_status_force
